// ---- hdl/flash_ctl.sv ----
// flash mode and protection controller driving the parallel flash pins
// Behaviour
// - high-voltage id: A6 low, A1/A0 select
// - sector address on top bits; 00h unprotected
// - protect all sectors before unprotect
// - unlock cycles precede every program command
// - write only with ce, we low, oe high
// - timeout flag high means write reset
// - reset accepted at any address, leaves id
//
// Strobed register access and the placing of the registers were chosen for this implementation.
module flash_ctl (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // software port
  input wire logic [3:0] sw_addr,
  input wire logic [31:0] sw_wdata,
  input wire logic sw_wr,
  input wire logic sw_rd,
  output logic [31:0] sw_rdata,
  // flash pins
  output flash_ctl_pkg::flash_pins_t pins,
  input wire logic [15:0] dq_in
);
  // ****************************************
  // sequencer state
  // ****************************************
  typedef enum logic [5:0] {
    S_IDLE = 6'b000001,
    S_SETUP = 6'b000010,
    S_STROBE = 6'b000100,
    S_HOLD = 6'b001000,
    S_NEXT = 6'b010000,
    S_HWRST = 6'b100000
  } state_t;

  state_t state_r, state_nxt;
  logic [7:0] cnt_r, cnt_nxt;
  logic [1:0] step_r, step_nxt;
  logic [1:0] last_r, last_nxt;
  logic is_read_r, is_read_nxt;
  logic [2:0] op_r, op_nxt;
  logic hv_id_r, hv_id_nxt;
  logic hv_rst_r, hv_rst_nxt;
  logic [19:0] addr_r, addr_nxt;
  logic [15:0] wdata_r, wdata_nxt;
  logic [15:0] rdata_r, rdata_nxt;
  logic done_r, done_nxt;
  logic timeout_r, timeout_nxt;
  logic bad_r, bad_nxt;
  logic [31:0] sw_rdata_nxt;
  flash_ctl_pkg::flash_pins_t pins_nxt;
  logic [15:0] dq_s1_r, dq_s2_r, dq_s3_r;

  // data of one bus cycle within a command sequence
  function automatic logic [35:0] cycle_of(input logic [2:0] op, input logic [1:0] step,
                                           input logic [19:0] a, input logic [15:0] d);
    case (step)
      2'd0: cycle_of = {flash_ctl_pkg::UNLOCK_ADDR1, 8'h00, flash_ctl_pkg::UNLOCK_DATA1};
      2'd1: cycle_of = {flash_ctl_pkg::UNLOCK_ADDR2, 8'h00, flash_ctl_pkg::UNLOCK_DATA2};
      2'd2: cycle_of = {flash_ctl_pkg::UNLOCK_ADDR1, 8'h00,
                        (op == flash_ctl_pkg::OP_ID_ENTER) ? flash_ctl_pkg::CMD_ID : flash_ctl_pkg::CMD_PROGRAM};
      default: cycle_of = {a, d};
    endcase
  endfunction

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    logic go;
    logic [35:0] cyc;
    go = 1'b0;
    cyc = 36'h0_0000_0000;
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    step_nxt = step_r;
    last_nxt = last_r;
    is_read_nxt = is_read_r;
    op_nxt = op_r;
    hv_id_nxt = hv_id_r;
    hv_rst_nxt = hv_rst_r;
    addr_nxt = addr_r;
    wdata_nxt = wdata_r;
    rdata_nxt = rdata_r;
    done_nxt = done_r;
    timeout_nxt = timeout_r;
    bad_nxt = bad_r;
    pins_nxt = pins;
    sw_rdata_nxt = 32'h0000_0000;
    if (sw_wr) begin
      case (sw_addr)
        flash_ctl_pkg::REG_CTRL: begin
          op_nxt = sw_wdata[flash_ctl_pkg::CTRL_OP_HI:flash_ctl_pkg::CTRL_OP_LO];
          hv_id_nxt = sw_wdata[flash_ctl_pkg::CTRL_HV_ID];
          hv_rst_nxt = sw_wdata[flash_ctl_pkg::CTRL_HV_RST];
          go = sw_wdata[flash_ctl_pkg::CTRL_GO];
        end
        flash_ctl_pkg::REG_ADDR: addr_nxt = sw_wdata[19:0];
        flash_ctl_pkg::REG_WDATA: wdata_nxt = sw_wdata[15:0];
        default: ;
      endcase
    end
    if (sw_rd) begin
      case (sw_addr)
        flash_ctl_pkg::REG_CTRL: sw_rdata_nxt = {26'h000_0000, hv_rst_r, hv_id_r, op_r, 1'b0};
        flash_ctl_pkg::REG_ADDR: sw_rdata_nxt = {12'h000, addr_r};
        flash_ctl_pkg::REG_WDATA: sw_rdata_nxt = {16'h0000, wdata_r};
        flash_ctl_pkg::REG_STATUS: sw_rdata_nxt = {28'h000_0000, bad_r, done_r, timeout_r, state_r != S_IDLE};
        flash_ctl_pkg::REG_RDATA: sw_rdata_nxt = {16'h0000, rdata_r};
        default: sw_rdata_nxt = 32'h0000_0000;
      endcase
    end
    pins_nxt.rst_hv = hv_rst_nxt;
    pins_nxt.addr_hv = hv_id_nxt;
    case (state_r)
      S_IDLE: begin
        pins_nxt.ce_n = 1'b1;
        pins_nxt.oe_n = 1'b1;
        pins_nxt.we_n = 1'b1;
        pins_nxt.dq_oe = 1'b0;
        pins_nxt.rst_n = 1'b1;
        if (go) begin
          done_nxt = 1'b0;
          bad_nxt = 1'b0;
          step_nxt = 2'd3;
          last_nxt = 2'd3;
          is_read_nxt = 1'b0;
          cnt_nxt = flash_ctl_pkg::SETUP_CYC;
          state_nxt = S_SETUP;
          case (op_nxt)
            flash_ctl_pkg::OP_READ: is_read_nxt = 1'b1;
            flash_ctl_pkg::OP_WRITE: ;
            flash_ctl_pkg::OP_RESET: wdata_nxt = {8'h00, flash_ctl_pkg::CMD_RESET};
            flash_ctl_pkg::OP_ID_ENTER: begin
              step_nxt = 2'd0;
              last_nxt = 2'd2;
            end
            flash_ctl_pkg::OP_PROGRAM: step_nxt = 2'd0;
            flash_ctl_pkg::OP_HW_RESET: begin
              cnt_nxt = flash_ctl_pkg::HWRST_CYC;
              state_nxt = S_HWRST;
            end
            default: begin
              bad_nxt = 1'b1;
              done_nxt = 1'b1;
              state_nxt = S_IDLE;
            end
          endcase
        end
      end
      S_SETUP: begin
        // ce and address settle first, strobe opens last
        cyc = cycle_of(op_r, step_r, addr_r, wdata_r);
        pins_nxt.addr = cyc[35:16];
        pins_nxt.dq_out = cyc[15:0];
        pins_nxt.dq_oe = ~is_read_r;
        pins_nxt.ce_n = 1'b0;
        pins_nxt.oe_n = 1'b1;
        cnt_nxt = cnt_r - 8'h01;
        if (cnt_r <= 8'h01) begin
          // strobe held well above the glitch width
          cnt_nxt = is_read_r ? flash_ctl_pkg::ACCESS_CYC : flash_ctl_pkg::STROBE_CYC;
          state_nxt = S_STROBE;
        end
      end
      S_STROBE: begin
        if (is_read_r) begin
          pins_nxt.oe_n = 1'b0;
        end else begin
          pins_nxt.we_n = 1'b0;
        end
        cnt_nxt = cnt_r - 8'h01;
        if (cnt_r <= 8'h01) begin
          cnt_nxt = flash_ctl_pkg::HOLD_CYC;
          state_nxt = S_HOLD;
        end
      end
      S_HOLD: begin
        // strobe closes before ce so data is latched on we rising
        // take the word only once the last two sampling stages agree
        if (is_read_r && !pins.oe_n && dq_s2_r == dq_s3_r) begin
          rdata_nxt = dq_s3_r;
          timeout_nxt = dq_s3_r[flash_ctl_pkg::TIMEOUT_BIT];
        end
        pins_nxt.we_n = 1'b1;
        pins_nxt.oe_n = 1'b1;
        cnt_nxt = cnt_r - 8'h01;
        if (cnt_r <= 8'h01) begin
          pins_nxt.ce_n = 1'b1;
          pins_nxt.dq_oe = 1'b0;
          state_nxt = S_NEXT;
        end
      end
      S_NEXT: begin
        if (step_r == last_r) begin
          done_nxt = 1'b1;
          state_nxt = S_IDLE;
        end else begin
          step_nxt = step_r + 2'd1;
          cnt_nxt = flash_ctl_pkg::SETUP_CYC;
          state_nxt = S_SETUP;
        end
      end
      S_HWRST: begin
        pins_nxt.rst_n = 1'b0;
        cnt_nxt = cnt_r - 8'h01;
        if (cnt_r <= 8'h01) begin
          pins_nxt.rst_n = 1'b1;
          done_nxt = 1'b1;
          timeout_nxt = 1'b0;
          state_nxt = S_IDLE;
        end
      end
      default: state_nxt = S_IDLE;
    endcase
    // selector line forced low whenever the id line is at high voltage
    if (pins_nxt.addr_hv) begin
      pins_nxt.addr[flash_ctl_pkg::ID_GUARD_BIT] = 1'b0;
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge clk) begin
    dq_s1_r <= dq_in;
    dq_s2_r <= dq_s1_r;
    dq_s3_r <= dq_s2_r;
    if (reset) begin
      state_r <= S_IDLE;
      cnt_r <= 8'h00;
      step_r <= 2'd0;
      last_r <= 2'd0;
      is_read_r <= 1'b0;
      op_r <= flash_ctl_pkg::OP_READ;
      hv_id_r <= 1'b0;
      hv_rst_r <= 1'b0;
      addr_r <= 20'h00000;
      wdata_r <= 16'h0000;
      rdata_r <= 16'h0000;
      done_r <= 1'b0;
      timeout_r <= 1'b0;
      bad_r <= 1'b0;
      sw_rdata <= 32'h0000_0000;
      pins <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, rst_n: 1'b1, rst_hv: 1'b0, addr_hv: 1'b0,
                addr: 20'h00000, dq_out: 16'h0000, dq_oe: 1'b0};
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      step_r <= step_nxt;
      last_r <= last_nxt;
      is_read_r <= is_read_nxt;
      op_r <= op_nxt;
      hv_id_r <= hv_id_nxt;
      hv_rst_r <= hv_rst_nxt;
      addr_r <= addr_nxt;
      wdata_r <= wdata_nxt;
      rdata_r <= rdata_nxt;
      done_r <= done_nxt;
      timeout_r <= timeout_nxt;
      bad_r <= bad_nxt;
      sw_rdata <= sw_rdata_nxt;
      pins <= pins_nxt;
    end
  end
endmodule

// ---- hdl/flash_ctl_pkg.sv ----
// package: constants, commands and carriers of the flash mode and protection controller
package flash_ctl_pkg;
  // software register offsets (word index on the plain port)
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_ADDR = 4'h1;
  localparam logic [3:0] REG_WDATA = 4'h2;
  localparam logic [3:0] REG_STATUS = 4'h3;
  localparam logic [3:0] REG_RDATA = 4'h4;
  // control register fields
  localparam int CTRL_GO = 0;
  localparam int CTRL_OP_LO = 1;
  localparam int CTRL_OP_HI = 3;
  localparam int CTRL_HV_ID = 4;
  localparam int CTRL_HV_RST = 5;
  localparam logic [31:0] CTRL_RESET_VALUE = 32'h0000_0000;
  // operation codes in the control register
  localparam logic [2:0] OP_READ = 3'h0;
  localparam logic [2:0] OP_WRITE = 3'h1;
  localparam logic [2:0] OP_RESET = 3'h2;
  localparam logic [2:0] OP_ID_ENTER = 3'h3;
  localparam logic [2:0] OP_PROGRAM = 3'h4;
  localparam logic [2:0] OP_HW_RESET = 3'h5;
  // status register fields
  localparam int STAT_BUSY = 0;
  localparam int STAT_TIMEOUT = 1;
  localparam int STAT_DONE = 2;
  localparam int STAT_BAD_OP = 3;
  // command bytes and unlock addresses, set per part
  localparam logic [7:0] CMD_RESET = 8'hF0;
  localparam logic [7:0] CMD_ID = 8'h90;
  localparam logic [7:0] CMD_PROGRAM = 8'hA0;
  localparam logic [7:0] UNLOCK_DATA1 = 8'hAA;
  localparam logic [7:0] UNLOCK_DATA2 = 8'h55;
  localparam logic [19:0] UNLOCK_ADDR1 = 20'h00555;
  localparam logic [19:0] UNLOCK_ADDR2 = 20'h002AA;
  // identifier selector addresses on the low lines
  localparam logic [19:0] ID_MFR_ADDR = 20'h00000;
  localparam logic [19:0] ID_DEV_ADDR = 20'h00001;
  localparam logic [19:0] ID_PROT_ADDR = 20'h00002;
  localparam logic [7:0] PROT_CLEAR = 8'h00;
  // address line held low while the high-voltage id line is raised
  localparam int ID_GUARD_BIT = 6;
  localparam int TIMEOUT_BIT = 5;
  // pin timing
  localparam int CLK_NS = 10;
  localparam int SETUP_NS = 30;
  localparam int STROBE_NS = 60;
  localparam int HOLD_NS = 30;
  localparam int ACCESS_NS = 150;
  localparam int HWRST_NS = 500;
  localparam int GLITCH_NS = 5;
  localparam logic [7:0] SETUP_CYC = 8'((SETUP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] STROBE_CYC = 8'((STROBE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] HOLD_CYC = 8'((HOLD_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] ACCESS_CYC = 8'((ACCESS_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] HWRST_CYC = 8'((HWRST_NS + CLK_NS - 1) / CLK_NS);
  // pins toward the flash
  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic rst_n;
    logic rst_hv;
    logic addr_hv;
    logic [19:0] addr;
    logic [15:0] dq_out;
    logic dq_oe;
  } flash_pins_t;
endpackage

// ---- sim/flash_ctl_props.sv ----
// checker for the pin protocol of the flash controller
module flash_ctl_props (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // watched ports
  input wire logic sw_rd,
  input wire logic [31:0] sw_rdata,
  input wire flash_ctl_pkg::flash_pins_t pins
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // properties
  // ****
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  a_write_gate: assert property (!pins.we_n |-> pins.oe_n && !pins.ce_n)
    else $error("write without gate");
  a_drive_in_write: assert property (pins.dq_oe |-> pins.oe_n)
    else $error("data driven in read");
  a_we_width: assert property ($fell(pins.we_n) |-> !pins.we_n [*6] ##1 pins.we_n)
    else $error("write pulse width");
  a_oe_width: assert property ($fell(pins.oe_n) |-> !pins.oe_n [*8])
    else $error("read pulse width");
  a_latch_stable: assert property (
    !pins.we_n && !$past(pins.we_n) |-> $stable(pins.addr) && $stable(pins.dq_out)) else $error("latch moved");
  a_hv_sel_low: assert property (pins.addr_hv |-> !pins.addr[6])
    else $error("selector line high");
  a_rdata_idle: assert property (!$past(sw_rd) |-> sw_rdata == 32'h0)
    else $error("read data outside slot");
  a_hw_reset_len: assert property ($fell(pins.rst_n) |-> !pins.rst_n [*8])
    else $error("reset pulse short");
  a_reset_pins_idle: assert property (disable iff (1'b0) reset |=> pins.ce_n && pins.we_n && pins.rst_n)
    else $error("pins active in reset");
  cover property ($fell(pins.we_n));
  cover property ($fell(pins.oe_n) && pins.addr_hv);
  cover property ($fell(pins.rst_n));
endmodule

bind flash_ctl flash_ctl_props chk (.clk(clk), .reset(reset), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .pins(pins));

// ---- sim/flash_dev_model.sv ----
// behavioural flash device answering the controller pins
module flash_dev_model #(
  parameter logic [7:0] MFR_CODE = 8'h5A, // arbitrary value
  parameter logic [7:0] DEV_CODE = 8'hC3 // arbitrary value
) (
  // pins from the controller
  input wire flash_ctl_pkg::flash_pins_t pins,
  // protection map, timeout fault and write lockout
  input wire logic [15:0] prot,
  input wire logic stuck,
  input wire logic lockout,
  // data lines back
  output logic [15:0] dq
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // command decoder and read path
  // ****
  logic [15:0] mem [int];
  logic [15:0] rv;
  logic [15:0] last = 16'h0000;
  logic [19:0] la;
  logic idm = 1'b0;
  logic tmo = 1'b0;
  logic armed = 1'b0;
  int step = 0;
  time tf;
  wire wr_n = pins.ce_n | pins.we_n | !pins.oe_n;
  task automatic cmd(input logic [15:0] d);
    if (step == 3) begin
      if (stuck) tmo = 1'b1;
      else if (!prot[la[19:16]] || pins.rst_hv) mem[la] = d;
      step = 0;
    end else if (d[7:0] == flash_ctl_pkg::CMD_RESET) begin
      step = 0;
      idm = 1'b0;
      tmo = 1'b0;
    end else if (step < 2 && la == (step ? flash_ctl_pkg::UNLOCK_ADDR2 : flash_ctl_pkg::UNLOCK_ADDR1)
                 && d[7:0] == (step ? flash_ctl_pkg::UNLOCK_DATA2 : flash_ctl_pkg::UNLOCK_DATA1)) step++;
    else if (step == 2 && la == flash_ctl_pkg::UNLOCK_ADDR1 && d[7:0] == flash_ctl_pkg::CMD_ID) begin
      idm = 1'b1;
      step = 0;
    end else if (step == 2 && la == flash_ctl_pkg::UNLOCK_ADDR1 && d[7:0] == flash_ctl_pkg::CMD_PROGRAM) step = 3;
    else begin
      step = 0;
      idm = 1'b0;
    end
  endtask
  always @(negedge wr_n) begin
    la = pins.addr;
    tf = $time;
    armed = 1'b1;
  end
  // a rising edge with no falling edge since power-up carries no command
  always @(posedge wr_n) begin
    if (armed && !lockout && pins.rst_n && $time - tf >= 5) cmd(pins.dq_out);
    armed = 1'b0;
  end
  always @(posedge lockout) begin
    step = 0;
    idm = 1'b0;
    tmo = 1'b0;
  end
  always @(negedge pins.rst_n) begin
    step = 0;
    idm = 1'b0;
    tmo = 1'b0;
  end
  always @(pins or idm or tmo) begin
    if (tmo) rv = 16'h0020;
    else if (idm || pins.addr_hv) rv = pins.addr[1:0] == 2'h0 ? {8'h00, MFR_CODE} :
      pins.addr[1:0] == 2'h1 ? {8'h00, DEV_CODE} : {15'h0000, prot[pins.addr[19:16]]};
    else rv = mem.exists(pins.addr) ? mem[pins.addr] : ~pins.addr[15:0];
  end
  always @(pins or rv) begin
    if (!pins.ce_n && !pins.oe_n && pins.rst_n) last = rv;
    dq = (!pins.ce_n && !pins.oe_n && pins.rst_n) ? rv : ~last;
  end
endmodule

// ---- sim/flash_ctl_test.sv ----
// self-checking bench of the flash controller against a device model
module flash_ctl_test;
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // bench
  // ****
  localparam logic [7:0] MFR = 8'h5A; // arbitrary value
  localparam logic [7:0] DEV = 8'hC3; // arbitrary value
  logic clk, reset, sw_wr, sw_rd, stuck, lockout;
  logic [3:0] sw_addr;
  logic [31:0] sw_wdata, sw_rdata, v;
  logic [15:0] dq, prot, d;
  logic [19:0] a;
  logic [15:0] ref_mem [int];
  int fail_count, cmp_count, cyc, n;
  flash_ctl_pkg::flash_pins_t pins;
  flash_ctl dut (.clk(clk), .reset(reset), .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr),
    .sw_rd(sw_rd), .sw_rdata(sw_rdata), .pins(pins), .dq_in(pins.dq_oe ? pins.dq_out : dq));
  flash_dev_model #(.MFR_CODE(MFR), .DEV_CODE(DEV)) dev (.pins(pins), .prot(prot), .stuck(stuck),
    .lockout(lockout), .dq(dq));
  task automatic summarize;
    if (fail_count == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] w);
    cmp_count++;
    if (g !== w) begin
      fail_count++;
      $display("CHECK FAILED %0t got %h want %h", $time, g, w);
    end
  endtask
  task automatic wr(input logic [3:0] ad, input logic [31:0] x);
    sw_addr <= ad;
    sw_wdata <= x;
    sw_wr <= 1'b1;
    @(posedge clk);
    sw_wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [3:0] ad);
    sw_addr <= ad;
    sw_rd <= 1'b1;
    @(posedge clk);
    sw_rd <= 1'b0;
    #1 v = sw_rdata;
    @(posedge clk);
  endtask
  task automatic run(input logic [2:0] op, input logic [19:0] ad, input logic [15:0] x, input logic [1:0] hv);
    wr(flash_ctl_pkg::REG_ADDR, {12'h000, ad});
    wr(flash_ctl_pkg::REG_WDATA, {16'h0000, x});
    wr(flash_ctl_pkg::REG_CTRL, {26'h0000000, hv, op, 1'b1});
    n = 0;
    do begin
      rd(flash_ctl_pkg::REG_STATUS);
      n++;
    end while ({v[flash_ctl_pkg::STAT_DONE], v[flash_ctl_pkg::STAT_BUSY]} !== 2'h2 && n < 300);
    chk({15'h0000, v[flash_ctl_pkg::STAT_BUSY]}, 16'h0000);
  endtask
  function automatic logic [15:0] ex(input logic [19:0] ad);
    return ref_mem.exists(ad) ? ref_mem[ad] : ~ad[15:0];
  endfunction
  task automatic rdx(input logic [19:0] ad, input logic [1:0] hv, input logic [15:0] w);
    run(flash_ctl_pkg::OP_READ, ad, 16'h0000, hv);
    rd(flash_ctl_pkg::REG_RDATA);
    chk(v[15:0], w);
  endtask
  task automatic pgm(input logic [15:0] x, input logic hvr);
    run(flash_ctl_pkg::OP_PROGRAM, a, x, {hvr, 1'b0});
    if (!prot[a[19:16]] || hvr) ref_mem[a] = x;
    rdx(a, 2'h0, ex(a));
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      fail_count++;
      $display("CHECK FAILED %0t run did not finish in time", $time);
      summarize();
    end
  end
  initial begin
    reset = 1'b1;
    sw_wr = 1'b0;
    sw_rd = 1'b0;
    sw_addr = 4'h0;
    sw_wdata = 32'h0;
    prot = 16'h0000;
    stuck = 1'b0;
    lockout = 1'b0;
    void'($urandom(71));
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    rd(flash_ctl_pkg::REG_CTRL);
    chk(v, flash_ctl_pkg::CTRL_RESET_VALUE);
    repeat (3) begin
      a = 20'($urandom);
      rdx(a, 2'h0, ex(a));
      pgm(16'($urandom), 1'b0);
    end
    rd(flash_ctl_pkg::REG_ADDR);
    chk(v, {12'h000, a});
    for (int k = 0; k < 4; k++) run(flash_ctl_pkg::OP_WRITE, k == 3 ? a : k == 1 ? 20'h002AA : 20'h00555,
      k == 0 ? 16'h00AA : k == 1 ? 16'h0077 : k == 2 ? 16'h00A0 : 16'h1234, 2'h0);
    rdx(a, 2'h0, ex(a));
    prot = 16'hFFFF;
    pgm(16'h0F0F, 1'b0);
    pgm(16'h0F0F, 1'b1);
    pgm(16'h3C3C, 1'b0);
    prot = 16'h0000;
    pgm(16'h3C3C, 1'b0);
    lockout = 1'b1;
    run(flash_ctl_pkg::OP_PROGRAM, a, 16'hA5A5, 2'h0);
    lockout = 1'b0;
    rdx(a, 2'h0, ex(a));
    prot = 16'h0001 << a[19:16];
    run(flash_ctl_pkg::OP_ID_ENTER, 20'h00000, 16'h0000, 2'h0);
    for (int k = 0; k < 12; k++) begin
      if (k == 6) run(flash_ctl_pkg::OP_RESET, 20'($urandom), 16'h0000, 2'h0);
      d = k % 3 == 0 ? {8'h00, MFR} : k % 3 == 1 ? {8'h00, DEV} : {15'h0000, prot[a[19:16] + 4'(k % 6 / 3)]};
      rdx({a[19:16] + 4'(k % 6 / 3), 14'h0000, 2'(k % 3)}, {1'b0, k > 5}, d);
    end
    rdx(a, 2'h0, ex(a));
    run(flash_ctl_pkg::OP_ID_ENTER, 20'h00000, 16'h0000, 2'h0);
    run(flash_ctl_pkg::OP_HW_RESET, 20'h00000, 16'h0000, 2'h0);
    rdx(a, 2'h0, ex(a));
    for (int o = 6; o < 8; o++) begin
      run(3'(o), a, 16'h0000, 2'h0);
      chk({15'h0000, v[flash_ctl_pkg::STAT_BAD_OP]}, 16'h0001);
    end
    stuck = 1'b1;
    run(flash_ctl_pkg::OP_PROGRAM, a, 16'h5555, 2'h0);
    stuck = 1'b0;
    rdx(a, 2'h0, 16'h0020);
    rd(flash_ctl_pkg::REG_STATUS);
    chk({15'h0000, v[flash_ctl_pkg::STAT_TIMEOUT]}, 16'h0001);
    run(flash_ctl_pkg::OP_RESET, 20'($urandom), 16'h0000, 2'h0);
    rdx(a, 2'h0, ex(a));
    summarize();
  end
endmodule
